// ### adc_control_registers.v
// Register file, start/busy sequencing, input routing and result formatting
// for a 12-bit successive-approximation converter, reached over APB.
// Assumes the analog core converts on conv_start_q and returns a result with
// core_done after counting conversion clock ticks; ports are synchronous to pclk.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module adc_control_registers
#(
  parameter NCHAN  = 12,
  parameter RES_W  = 12,
  parameter CLK_W  = 3
)
(
  // APB slave
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Analog core
  input  wire              core_done,
  input  wire [RES_W-1:0]  core_result,
  output reg               conv_start_q,
  output reg               conv_power_q,
  output reg               conv_clk_tick_q,
  output reg  [2:0]        input_route_q,
  output reg  [NCHAN-1:0]  chan_connect_q,
  output reg  [1:0]        ref_route_q,
  output reg               ref_pin_connect_q,
  output reg               amp_power_q,
  output reg               amp_input_bandgap_q,
  output reg  [1:0]        amp_gain_q,
  output reg               bandgap_power_q,
  // Pin sharing
  output reg  [NCHAN-1:0]  pin_gpio_release_q,
  output reg  [NCHAN-1:0]  pin_pullup_disable_q
);

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  reg              start_q;
  reg              busy_q;
  reg              enable_q;
  reg              align_q;
  reg  [3:0]       chan_q;
  reg  [7:0]       ctrl_one_q;
  reg  [7:0]       ctrl_two_q;
  reg              bandgap_q;
  reg  [NCHAN-1:0] pin_sel_q;
  reg  [7:0]       result_low_q;
  reg  [7:0]       result_high_q;

  wire             wr_en;
  wire             rd_en;
  wire             conv_tick;
  wire [3:0]       src_field;
  wire [7:0]       wbyte;
  reg              mapped;
  reg  [7:0]       rd_byte;
  reg  [2:0]       route_d;
  reg  [1:0]       ref_d;
  wire             wr_ctrl_zero;
  wire             wr_ctrl_one;
  wire             wr_ctrl_two;
  wire             wr_bandgap;
  wire             wr_pin_sel;
  wire             start_seen;
  wire             busy_end;

  assign wr_en     = psel && penable && pwrite && !pready;
  assign rd_en     = psel && penable && !pwrite && !pready;
  assign wbyte     = pwdata[7:0];
  assign src_field = ctrl_one_q[`C1_SRC_HI:`C1_SRC_LO];

  // ---------------------------------------------
  // Write decode
  // ---------------------------------------------
  // Registers take a write at the end of the first access cycle, on the edge that raises pready
  assign wr_ctrl_zero = wr_en && (paddr == `OFF_CTRL_ZERO);
  assign wr_ctrl_one  = wr_en && (paddr == `OFF_CTRL_ONE);
  assign wr_ctrl_two  = wr_en && (paddr == `OFF_CTRL_TWO);
  assign wr_bandgap   = wr_en && (paddr == `OFF_BANDGAP);
  assign wr_pin_sel   = wr_en && (paddr == `OFF_PIN_SELECT);
  // Start bit high then low; a start while busy or disabled is dropped
  assign start_seen   = wr_ctrl_zero && start_q && !wbyte[`C0_START] &&
                        !busy_q && wbyte[`C0_ENABLE];
  // Done ends the conversion; disabling the converter aborts it
  assign busy_end     = busy_q && (core_done || !enable_q);

  // ---------------------------------------------
  // APB write side and start/busy sequencing
  // ---------------------------------------------
  // A start is the falling edge of the software start bit; busy cannot be
  // written because it is never taken from wbyte.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q      <= 1'b0;
      busy_q       <= 1'b0;
      enable_q     <= 1'b0;
      align_q      <= 1'b0;
      chan_q       <= 4'h0;
      ctrl_one_q   <= `RST_BYTE;
      ctrl_two_q   <= `RST_BYTE;
      bandgap_q    <= 1'b0;
      pin_sel_q    <= `RST_PINS;
      conv_start_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= 1'b0;
      if (wr_ctrl_zero)
      begin
        start_q  <= wbyte[`C0_START];
        enable_q <= wbyte[`C0_ENABLE];
        align_q  <= wbyte[`C0_ALIGN];
        chan_q   <= wbyte[`C0_CHAN_HI:`C0_CHAN_LO];
      end
      if (wr_ctrl_one)
        ctrl_one_q <= wbyte & `C1_WMASK;
      if (wr_ctrl_two)
        ctrl_two_q <= wbyte & `C2_WMASK;
      if (wr_bandgap)
        bandgap_q <= wbyte[`BG_ENABLE];
      if (wr_pin_sel)
        pin_sel_q <= pwdata[NCHAN-1:0];
      // Busy moves only on start and end; a start needs busy low, so they never meet
      if (start_seen)
      begin
        busy_q       <= 1'b1;
        conv_start_q <= 1'b1;
      end
      else if (busy_end)
        busy_q <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Result capture
  // ---------------------------------------------
  // Captured only on done while enabled, in the same edge busy drops.
  // A done that arrives after the enable fell leaves the old result in place.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_low_q  <= `RST_BYTE;
      result_high_q <= `RST_BYTE;
    end
    else if (busy_q && core_done && enable_q)
    begin
      if (!align_q)
      begin
        result_high_q <= core_result[11:4];
        result_low_q  <= {core_result[3:0], 4'h0};
      end
      else
      begin
        result_high_q <= {4'h0, core_result[11:8]};
        result_low_q  <= core_result[7:0];
      end
    end
  end

  // ---------------------------------------------
  // Input and reference routing
  // ---------------------------------------------
  always @*
  begin
    case (src_field)
      `SRC_VDD:      route_d = `ROUTE_VDD;
      `SRC_VDD_HALF: route_d = `ROUTE_VDD_HALF;
      `SRC_VDD_QTR:  route_d = `ROUTE_VDD_QTR;
      `SRC_AMP:      route_d = `ROUTE_AMP;
      `SRC_AMP_HALF: route_d = `ROUTE_AMP_HALF;
      `SRC_AMP_QTR:  route_d = `ROUTE_AMP_QTR;
      default:
        if (src_field[3:2] == `SRC_GND_TOP)
          route_d = `ROUTE_GND;
        else
          route_d = `ROUTE_EXT;
    endcase
    case (ctrl_two_q[`C2_REF_HI:`C2_REF_LO])
      `REF_VDD: ref_d = `REFSEL_VDD;
      `REF_PIN: ref_d = `REFSEL_PIN;
      default:  ref_d = `REFSEL_AMP;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_route_q       <= `ROUTE_EXT;
      ref_route_q         <= `REFSEL_VDD;
      ref_pin_connect_q   <= 1'b0;
      conv_power_q        <= 1'b0;
      amp_power_q         <= 1'b0;
      amp_input_bandgap_q <= 1'b0;
      amp_gain_q          <= 2'b00;
      bandgap_power_q     <= 1'b0;
    end
    else
    begin
      input_route_q       <= route_d;
      ref_route_q         <= ref_d;
      ref_pin_connect_q   <= (ref_d == `REFSEL_PIN);
      conv_power_q        <= enable_q;
      amp_power_q         <= ctrl_two_q[`C2_AMP_EN];
      amp_input_bandgap_q <= ctrl_two_q[`C2_AMP_IN];
      amp_gain_q          <= ctrl_two_q[`C2_GAIN_HI:`C2_GAIN_LO];
      bandgap_power_q     <= bandgap_q;
    end
  end

  // One switch per channel; codes above the last channel close none
  genvar g;
  generate
    for (g = 0; g < NCHAN; g = g + 1)
    begin : g_chan
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          chan_connect_q[g]       <= 1'b0;
          pin_gpio_release_q[g]   <= 1'b0;
          pin_pullup_disable_q[g] <= 1'b0;
        end
        else
        begin
          // Internal sources open every external switch
          chan_connect_q[g] <= (route_d == `ROUTE_EXT) && (chan_q <= `CHAN_LAST)
                               && (chan_q == g);
          pin_gpio_release_q[g]   <= pin_sel_q[g];
          pin_pullup_disable_q[g] <= pin_sel_q[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------
  // Conversion clock
  // ---------------------------------------------
  // The divider runs only while converting, so every conversion sees the
  // same phase of the divided clock.
  conv_clock_div
  #(
    .SEL_W (CLK_W)
  )
  u_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (busy_q),
    .sel     (ctrl_one_q[`C1_CLK_HI:`C1_CLK_LO]),
    .tick    (conv_tick)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_clk_tick_q <= 1'b0;
    else
      conv_clk_tick_q <= conv_tick;
  end

  // ---------------------------------------------
  // APB read side
  // ---------------------------------------------
  always @*
  begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `OFF_RESULT_LOW:  rd_byte = result_low_q;
      `OFF_RESULT_HIGH: rd_byte = result_high_q;
      `OFF_CTRL_ZERO:   rd_byte = {start_q, busy_q, enable_q, align_q, chan_q};
      `OFF_CTRL_ONE:    rd_byte = ctrl_one_q;
      `OFF_CTRL_TWO:    rd_byte = ctrl_two_q;
      `OFF_BANDGAP:     rd_byte = {7'h00, bandgap_q};
      `OFF_PIN_SELECT:  rd_byte = 8'h00;
      default:          mapped  = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped && `PSLVERR_UNMAPPED;
      if (rd_en)
      begin
        // Pin select is wider than a byte, so it bypasses rd_byte
        if (paddr == `OFF_PIN_SELECT)
          prdata <= {{(32-NCHAN){1'b0}}, pin_sel_q};
        else
          prdata <= {24'h0000_00, rd_byte};
      end
      else
        prdata <= 32'h0000_0000;
    end
  end

endmodule

// ### adc_ctrl_checker_assertions.sv
// Port checker for the converter control block: APB answers, routing, start pulses.
// Assumes binding to adc_control_registers; sees only that module's ports.
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module adc_ctrl_checker
#(
  parameter NCHAN = 12
)
(
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Converter side
  input wire logic             conv_start_q,
  input wire logic             conv_power_q,
  input wire logic [2:0]       input_route_q,
  input wire logic [NCHAN-1:0] chan_connect_q
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence take_s;
    psel && penable && !pready;
  endsequence
  sequence wr0_s;
    take_s ##0 (pwrite && paddr == `OFF_CTRL_ZERO);
  endsequence

  answer_pulse_a: assert property (take_s |=> pready ##1 !pready)
    else $error("pready not a single pulse after the access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr seen without pready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside an answer");
  unmapped_read_a: assert property (take_s ##0 (!pwrite && paddr > `OFF_PIN_SELECT)
    |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped read not refused");
  gap_bit_a: assert property (take_s ##0 (!pwrite && paddr == `OFF_CTRL_ONE)
    |=> !prdata[3]) else $error("control one bit 3 read as one");
  power_follow_a: assert property (wr0_s |=> ##1
    conv_power_q == $past(pwdata[`C0_ENABLE], 2)) else $error("power level wrong");
  ext_cut_a: assert property (input_route_q != `ROUTE_EXT |-> chan_connect_q == '0)
    else $error("external switch closed with internal source");
  one_channel_a: assert property ($onehot0(chan_connect_q))
    else $error("more than one external switch closed");
  start_pulse_a: assert property (conv_start_q |=> !conv_start_q [*4])
    else $error("start pulse repeated too soon");
endmodule

bind adc_control_registers adc_ctrl_checker #(.NCHAN(NCHAN)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .conv_start_q, .conv_power_q, .input_route_q, .chan_connect_q
);

// ### adc_ctrl_defs.vh
// Register offsets, field positions, reset values and codes for the converter control block.
// Assumes inclusion by bare name from the design files.
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// ---------------------------------------------
// Register byte addresses (APB, word aligned)
// ---------------------------------------------
`define OFF_RESULT_LOW   12'h000
`define OFF_RESULT_HIGH  12'h004
`define OFF_CTRL_ZERO    12'h008
`define OFF_CTRL_ONE     12'h00C
`define OFF_CTRL_TWO     12'h010
`define OFF_BANDGAP      12'h014
`define OFF_PIN_SELECT   12'h018

// ---------------------------------------------
// Control register zero fields
// ---------------------------------------------
`define C0_START         7
`define C0_BUSY          6
`define C0_ENABLE        5
`define C0_ALIGN         4
`define C0_CHAN_HI       3
`define C0_CHAN_LO       0

// ---------------------------------------------
// Control register one and two fields, and the bandgap register field
// ---------------------------------------------
`define C1_SRC_HI        7
`define C1_SRC_LO        4
`define C1_CLK_HI        2
`define C1_CLK_LO        0
`define C2_AMP_EN        7
`define C2_AMP_IN        4
`define C2_REF_HI        3
`define C2_REF_LO        2
`define C2_GAIN_HI       1
`define C2_GAIN_LO       0
`define BG_ENABLE        0

// ---------------------------------------------
// Reset values and write masks
// ---------------------------------------------
`define RST_BYTE         8'h00
`define RST_PINS         12'h000
`define C1_WMASK         8'hF7
`define C2_WMASK         8'h9F

// ---------------------------------------------
// Codes
// ---------------------------------------------
`define CHAN_LAST        4'hB
`define SRC_VDD          4'h1
`define SRC_VDD_HALF     4'h2
`define SRC_VDD_QTR      4'h3
`define SRC_AMP          4'h5
`define SRC_AMP_HALF     4'h6
`define SRC_AMP_QTR      4'h7
`define SRC_GND_TOP      2'b10
`define REF_VDD          2'b00
`define REF_PIN          2'b01
`define ROUTE_EXT        3'd0
`define ROUTE_VDD        3'd1
`define ROUTE_VDD_HALF   3'd2
`define ROUTE_VDD_QTR    3'd3
`define ROUTE_AMP        3'd4
`define ROUTE_AMP_HALF   3'd5
`define ROUTE_AMP_QTR    3'd6
`define ROUTE_GND        3'd7
`define REFSEL_VDD       2'd0
`define REFSEL_PIN       2'd1
`define REFSEL_AMP       2'd2
`define PSLVERR_UNMAPPED 1'b1

`endif

// ### analog_core_model.sv
// Behavioural analog core: counts conversion ticks, then returns a sample.
// Assumes the pclk domain; the result line carries junk outside done.
`timescale 1ns/1ps

module analog_core_model
#(
  parameter TICKS = 4
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // From the block
  input  wire logic        conv_start_q,
  input  wire logic        conv_power_q,
  input  wire logic        conv_clk_tick_q,
  input  wire logic [11:0] sample,
  // To the block
  output logic             core_done,
  output logic [11:0]      core_result
);
  // --------------------
  // Conversion sequence
  // --------------------
  logic        run_q;
  int          ticks_q;
  logic [11:0] last_q;

  // Never repeat the last value outside done, so a stale read shows up
  assign core_result = core_done ? last_q : ~last_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q     <= 1'b0;
      ticks_q   <= 0;
      core_done <= 1'b0;
      last_q    <= 12'h000;
    end
    else
    begin
      core_done <= 1'b0;
      if (conv_start_q)
      begin
        run_q   <= 1'b1;
        ticks_q <= 0;
      end
      else if (!conv_power_q)
        run_q <= 1'b0;
      else if (run_q && conv_clk_tick_q && ticks_q == TICKS - 1)
      begin
        run_q     <= 1'b0;
        core_done <= 1'b1;
        last_q    <= sample;
      end
      else if (run_q && conv_clk_tick_q)
        ticks_q <= ticks_q + 1;
    end
  end
endmodule

// ### conv_clock_div.v
// Conversion clock enable generator: one pulse every 2**sel system clocks.
// Assumes a single system clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module conv_clock_div
#(
  parameter SEL_W = 3
)
(
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Control
  input  wire             run,
  input  wire [SEL_W-1:0] sel,
  // Output
  output reg              tick
);

  localparam CNT_W = (1 << SEL_W) - 1;

  reg  [CNT_W-1:0] cnt_q;
  wire [CNT_W-1:0] limit;

  // Terminal count is 2**sel - 1; sel of zero ticks every clock
  assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << sel) - {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q <= {CNT_W{1'b0}};
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule

// ### tb_adc_control_registers.sv
// Self-checking bench: APB transfers against the converter control block.
// Assumes design, header, checker and core model are compiled first.
`timescale 1ns/1ps
`include "adc_ctrl_defs.vh"

module tb_adc_control_registers;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        core_done, conv_start_q, conv_power_q, conv_clk_tick_q;
  logic        amp_power_q, bandgap_power_q, ref_pin, amp_in_bg;
  logic [1:0]  ref_route_q, amp_gain;
  logic [2:0]  input_route_q;
  logic [11:0] paddr, core_result, chan_connect_q, sample, gpio_rel, pull_off;
  logic [31:0] pwdata, prdata, rdat;
  int          bad_count, n_compared, starts, gap, last_gap, i;
  localparam logic [11:0] C0 = `OFF_CTRL_ZERO;
  localparam logic [11:0] C1 = `OFF_CTRL_ONE;

  adc_control_registers u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .core_done, .core_result, .conv_start_q, .conv_power_q, .conv_clk_tick_q,
    .input_route_q, .chan_connect_q, .ref_route_q, .ref_pin_connect_q(ref_pin), .amp_power_q,
    .amp_input_bandgap_q(amp_in_bg), .amp_gain_q(amp_gain), .bandgap_power_q,
    .pin_gpio_release_q(gpio_rel), .pin_pullup_disable_q(pull_off)
  );
  analog_core_model #(.TICKS(6)) u_core (
    .pclk, .presetn, .conv_start_q, .conv_power_q, .conv_clk_tick_q, .sample,
    .core_done, .core_result
  );

  // ----------------
  // Clock and monitors
  // ----------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (conv_start_q === 1'b1)
      starts <= starts + 1;
    gap <= conv_clk_tick_q ? 1 : gap + 1;
    if (conv_clk_tick_q === 1'b1)
      last_gap <= gap;
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is sampled, then idles one cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      bad_count++;
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do
      apb(1'b0, C0, 32'h0000_0000);
    while (rdat[`C0_BUSY] !== 1'b0 && ++n < 100);
    if (n >= 100)
      bad_count++;
  endtask
  function automatic logic [2:0] route_of(input int s);
    if (s inside {[1:3]})
      return 3'(s);
    if (s inside {[5:7]})
      return 3'(s - 1);
    return (s inside {[8:11]}) ? 3'd7 : 3'd0;
  endfunction
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial
  begin
    {psel, penable, pwrite, presetn} <= 4'h0;
    paddr  <= 12'h000;
    pwdata <= 32'h0000_0000;
    sample <= 12'hABC;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 7; i++)
      rd(12'(4 * i), 8'h00);
    rd(12'h01C, 8'h00);
    chk(err, 1'b1);
    wr(C0, 8'h4F);
    rd(C0, 8'h0F);
    wr(C1, 8'hFF);
    rd(C1, 8'hF7);
    wr(`OFF_CTRL_TWO, 8'hFF);
    chk(amp_power_q, 1'b1);
    chk(amp_in_bg, 1'b1);
    chk(amp_gain, 2'b11);
    chk(ref_pin, 1'b0);
    rd(`OFF_CTRL_TWO, 8'h9F);
    wr(`OFF_BANDGAP, 8'hFF);
    rd(`OFF_BANDGAP, 8'h01);
    chk(bandgap_power_q, 1'b1);
    wr(`OFF_BANDGAP, 8'h00);
    chk(bandgap_power_q, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      wr(`OFF_CTRL_TWO, 8'(i << 2));
      chk(ref_route_q, i > 1 ? 2 : i);
      chk(ref_pin, i == 1);
    end
    chk(amp_power_q, 1'b0);
    wr(`OFF_PIN_SELECT, 12'hA5C);
    chk(gpio_rel, 12'hA5C);
    chk(pull_off, 12'hA5C);
    rd(`OFF_PIN_SELECT, 32'h0000_0A5C);
    wr(C1, 8'h00);
    for (i = 0; i < 16; i++)
    begin
      wr(C0, 8'(i));
      chk(chan_connect_q, i < 12 ? 1 << i : 0);
    end
    wr(C0, 8'h05);
    for (i = 0; i < 16; i++)
    begin
      wr(C1, 8'(i << 4));
      chk(input_route_q, route_of(i));
      chk(chan_connect_q, route_of(i) == 3'd0 ? 12'h020 : 12'h000);
    end
    wr(C1, 8'h03);
    wr(C0, 8'hA0);
    wr(C0, 8'h20);
    chk(conv_power_q, 1'b1);
    rd(C0, 8'h60);
    wr(C0, 8'hA0);
    wr(C0, 8'h20);
    wait_idle;
    chk(starts, 1);
    chk(last_gap, 8);
    rd(`OFF_RESULT_HIGH, 8'hAB);
    rd(`OFF_RESULT_LOW, 8'hC0);
    sample <= 12'h5A3;
    wr(C0, 8'hB0);
    wr(C0, 8'h30);
    wait_idle;
    rd(`OFF_RESULT_HIGH, 8'h05);
    rd(`OFF_RESULT_LOW, 8'hA3);
    sample <= 12'h111;
    wr(C0, 8'hA0);
    wr(C0, 8'h20);
    wr(C0, 8'h00);
    chk(conv_power_q, 1'b0);
    wr(C0, 8'h80);
    wr(C0, 8'h00);
    wait_idle;
    chk(starts, 3);
    rd(`OFF_RESULT_LOW, 8'hA3);
    test_done;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done;
  end
endmodule
